/* File: design/sfrpe_engine.sv */
// Overview of operation
// RULE1: Fast read needs dummy byte, slow none
// RULE2: Host keeps clock within read limits
// RULE3: Read data MSB first, address auto-increments
// RULE4: Read wraps top address to zero
// RULE5: Chip select release ends read, tristates
// RULE6: Dual read: opcode, address, one dummy
// RULE7: Dual read sends bit pairs, four clocks
// RULE8: Dual read wraps to zero too
// RULE9: Release ends dual read, both lines tristate
// RULE10: Program: opcode, address, 1-256 buffered bytes
// RULE11: Program accepted only with latch set
// RULE12: Program offset wraps inside the page
// RULE13: Only last 256 bytes are kept
// RULE14: Release starts programming; unsent bytes untouched
// RULE15: Array write is self-timed
// RULE16: Short or misaligned program aborts
// RULE17: Protected target: no program, back idle
// RULE18: Any program abort clears write latch
// RULE19: Status readable and busy during program
// RULE20: Status interrupt drives output low at end
// RULE21: Write latch cleared before program ends
// RULE22: Failed byte sets program error flag
// RULE23: Bytes MSB first, framed by chip select
// RULE24: Top five address bits ignored
// RULE25: Unknown opcode ignored until reselect
// RULE26: Sample on rising, drive on falling
// RULE27: Second line driven only after dummy
`timescale 1ns/1ps
`default_nettype none

module sfrpe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } sfrpe_fifo_st_t;

    sfrpe_fifo_st_t r;
    sfrpe_fifo_st_t n;
    logic           push;
    logic           pop;

    assign in_ready  = r.cnt != FULL_CNT;
    assign out_valid = r.cnt != '0;
    // Head word comes from flops through the read index mux
    assign out_data  = r.mem[r.rp];

    always_comb
    begin
        n    = r;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push)
        begin
            n.mem[r.wp] = in_data;
            n.wp        = r.wp + PW'(1);
        end
        if (pop)
        begin
            n.rp = r.rp + PW'(1);
        end
        if (push && !pop)
        begin
            n.cnt = r.cnt + CW'(1);
        end
        else if (pop && !push)
        begin
            n.cnt = r.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end
endmodule

module sfrpe_engine (
    input  wire logic                         REF_CLK,
    input  wire logic                         SRST,
    input  wire logic                         SPI_CS_N,
    input  wire logic                         SPI_SCK,
    input  wire logic                         BIDIR_SECOND_LINE_IN,
    output logic                              BIDIR_SECOND_LINE_OUT,
    output logic                              BIDIR_SECOND_LINE_OE_N,
    output logic                              SPI_SO,
    output logic                              SPI_SO_OE_N,
    input  wire logic                         PROTECT_IN,
    output logic [sfrpe_pkg::ADDR_W-1:0]      ARR_RD_ADDR,
    input  wire logic [sfrpe_pkg::BYTE_W-1:0] ARR_RD_DATA,
    output logic                              ARR_WR_VALID,
    input  wire logic                         ARR_WR_READY,
    input  wire logic                         ARR_WR_FAIL,
    output logic [sfrpe_pkg::ADDR_W-1:0]      ARR_WR_ADDR,
    output logic [sfrpe_pkg::BYTE_W-1:0]      ARR_WR_DATA,
    output logic                              STATUS_BUSY,
    output logic                              WRITE_ENABLE_LATCH,
    output logic                              PROGRAM_ERROR_FLAG
);
    typedef struct packed {
        logic                                                  cs_s1;
        logic                                                  cs_s2;
        logic                                                  cs_d;
        logic                                                  sck_s1;
        logic                                                  sck_s2;
        logic                                                  sck_d;
        logic                                                  si_s1;
        logic                                                  si_s2;
        sfrpe_pkg::sfrpe_state_t                               st;
        logic [7:0]                                            cmd;
        logic                                                  cmd_ok;
        logic [7:0]                                            sh;
        logic [2:0]                                            bitcnt;
        logic [1:0]                                            abytes;
        logic [sfrpe_pkg::ADDR_W-1:0]                          addr;
        logic [sfrpe_pkg::ADDR_W-1:0]                          rd_addr;
        logic [7:0]                                            osh;
        logic [2:0]                                            ocnt;
        logic                                                  so;
        logic                                                  so_oe_n;
        logic                                                  bidir_second_line;
        logic                                                  sio_oe_n;
        logic                                                  asi_on;
        logic [sfrpe_pkg::BASE_W-1:0]                          pg_base;
        logic [sfrpe_pkg::PAGE_W-1:0]                          pg_off;
        logic                                                  got_byte;
        logic [255:0]                                          mask;
        logic [255:0][7:0]                                     pbuf;
        logic                                                  draining;
        logic [sfrpe_pkg::PAGE_W-1:0]                          drain_idx;
        logic                                                  push_vld;
        logic [sfrpe_pkg::WR_W-1:0]                            push_data;
        logic                                                  busy;
        logic                                                  write_enable_latch;
        logic                                                  program_error_flag;
    } sfrpe_top_st_t;

    sfrpe_top_st_t               r;
    sfrpe_top_st_t               n;
    logic                        sck_rise;
    logic                        sck_fall;
    logic                        cs_on;
    logic                        cs_off;
    logic                        fifo_in_rdy;
    logic                        fifo_out_vld;
    logic [sfrpe_pkg::WR_W-1:0]  fifo_out_data;
    logic                        prog_sel;

    function automatic logic [7:0] status_byte(input logic busy, input logic write_enable_latch, input logic program_error_flag);
        logic [7:0] sb;
        sb                        = 8'h00;
        sb[sfrpe_pkg::ST_BUSY_BIT] = busy;
        sb[sfrpe_pkg::ST_WEL_BIT]  = write_enable_latch;
        sb[sfrpe_pkg::ST_EPE_BIT]  = program_error_flag;
        return sb;
    endfunction

    // Edges are taken on the second synchroniser stage only
    assign sck_rise = r.sck_s2 && !r.sck_d;
    assign sck_fall = !r.sck_s2 && r.sck_d;
    assign cs_on    = r.cs_d && !r.cs_s2;
    assign cs_off   = !r.cs_d && r.cs_s2;
    assign prog_sel = (r.cmd == sfrpe_pkg::OP_PROGRAM) && r.cmd_ok;

    sfrpe_fifo #(
        .WIDTH (sfrpe_pkg::WR_W),
        .DEPTH (sfrpe_pkg::FIFO_DEPTH)
    ) wr_fifo (
        .clk       (REF_CLK),
        .srst      (SRST),
        .in_valid  (r.push_vld),
        .in_ready  (fifo_in_rdy),
        .in_data   (r.push_data),
        .out_valid (fifo_out_vld),
        .out_ready (ARR_WR_READY),
        .out_data  (fifo_out_data)
    );

    always_comb
    begin
        logic [7:0] sh_next;
        logic [7:0] obyte;
        logic       byte_done;
        logic       dual;
        sh_next   = {r.sh[6:0], r.si_s2};
        obyte     = r.osh;
        byte_done = r.bitcnt == sfrpe_pkg::BIT_LAST;
        dual      = r.cmd == sfrpe_pkg::OP_READ_DUAL;
        n         = r;
        n.cs_s1   = SPI_CS_N;
        n.cs_s2   = r.cs_s1;
        n.cs_d    = r.cs_s2;
        n.sck_s1  = SPI_SCK;
        n.sck_s2  = r.sck_s1;
        n.sck_d   = r.sck_s2;
        n.si_s1   = BIDIR_SECOND_LINE_IN;
        n.si_s2   = r.si_s1;

        // Buffer walked by offset; the FIFO stalls this walk when full
        if (r.push_vld && fifo_in_rdy)
        begin
            n.push_vld = 1'h0;
        end
        if (r.draining && (!r.push_vld || fifo_in_rdy))
        begin
            n.push_vld  = r.mask[r.drain_idx]; // [RULE14]
            n.push_data = {r.pg_base, r.drain_idx, r.pbuf[r.drain_idx]};
            n.drain_idx = r.drain_idx + 8'h01;
            if (r.drain_idx == sfrpe_pkg::PAGE_LAST)
            begin
                n.draining = 1'h0;
            end
        end
        // Busy holds until the array has taken every byte
        if (r.busy && !r.draining && !r.push_vld && !fifo_out_vld)
        begin
            n.busy = 1'h0; // [RULE15]
        end
        if (fifo_out_vld && ARR_WR_READY && ARR_WR_FAIL)
        begin
            n.program_error_flag = 1'h1; // [RULE22]
        end

        if (r.cs_s2)
        begin
            n.so_oe_n  = 1'h1; // [RULE5]
            n.sio_oe_n = 1'h1; // [RULE9]
            n.st       = sfrpe_pkg::SFRPE_IDLE; // [RULE23]
            n.asi_on   = 1'h0;
            if (cs_off && prog_sel)
            begin
                if (r.st == sfrpe_pkg::SFRPE_PDATA && r.got_byte && r.bitcnt == 3'h0
                    && !PROTECT_IN) // [RULE16] [RULE17]
                begin
                    n.busy      = 1'h1; // [RULE14]
                    n.draining  = 1'h1;
                    n.drain_idx = 8'h00;
                    n.write_enable_latch       = 1'h0; // [RULE21]
                    n.program_error_flag       = 1'h0;
                end
                else
                begin
                    n.write_enable_latch = 1'h0; // [RULE18]
                end
            end
            if (cs_off && r.cmd_ok && r.bitcnt == 3'h0)
            begin
                if (r.cmd == sfrpe_pkg::OP_WR_ENABLE)
                begin
                    n.write_enable_latch = 1'h1;
                end
                else if (r.cmd == sfrpe_pkg::OP_WR_DISABL)
                begin
                    n.write_enable_latch = 1'h0;
                end
            end
        end
        else if (cs_on)
        begin
            n.st       = sfrpe_pkg::SFRPE_OPC;
            n.bitcnt   = 3'h0;
            n.cmd      = 8'h00;
            n.cmd_ok   = 1'h0;
            n.got_byte = 1'h0;
            n.abytes   = 2'h0;
        end
        else if (sck_rise)
        begin
            n.sh     = sh_next; // [RULE26]
            n.bitcnt = r.bitcnt + 3'h1;
            if (byte_done)
            begin
                unique case (r.st)
                    sfrpe_pkg::SFRPE_OPC:
                    begin
                        n.cmd = sh_next;
                        n.st  = sfrpe_pkg::SFRPE_IGN; // [RULE25]
                        if (!r.busy && (sh_next == sfrpe_pkg::OP_READ_FAST
                            || sh_next == sfrpe_pkg::OP_READ_SLOW
                            || sh_next == sfrpe_pkg::OP_READ_DUAL))
                        begin
                            n.st     = sfrpe_pkg::SFRPE_ADDR;
                            n.cmd_ok = 1'h1;
                        end
                        else if (!r.busy && r.write_enable_latch && sh_next == sfrpe_pkg::OP_PROGRAM)
                        begin
                            n.st     = sfrpe_pkg::SFRPE_ADDR; // [RULE11]
                            n.cmd_ok = 1'h1;
                            n.mask   = '0;
                        end
                        else if (sh_next == sfrpe_pkg::OP_RD_STATUS)
                        begin
                            n.st   = sfrpe_pkg::SFRPE_STAT; // [RULE19]
                            n.ocnt = 3'h0;
                        end
                        else if (sh_next == sfrpe_pkg::OP_ACT_STAT)
                        begin
                            n.st = sfrpe_pkg::SFRPE_ASI;
                        end
                        else if (!r.busy && (sh_next == sfrpe_pkg::OP_WR_ENABLE
                            || sh_next == sfrpe_pkg::OP_WR_DISABL))
                        begin
                            n.cmd_ok = 1'h1;
                        end
                    end
                    sfrpe_pkg::SFRPE_ADDR:
                    begin
                        // Upper address bits fall off the top of the shift register
                        n.addr   = {r.addr[sfrpe_pkg::ADDR_W-sfrpe_pkg::BYTE_W-1:0],
                                    sh_next}; // [RULE24]
                        n.abytes = r.abytes + 2'h1;
                        if (r.abytes == sfrpe_pkg::ADDR_LAST)
                        begin
                            n.rd_addr = n.addr;
                            n.ocnt    = 3'h0;
                            n.pg_base = n.addr[sfrpe_pkg::ADDR_W-1:sfrpe_pkg::PAGE_W];
                            n.pg_off  = n.addr[sfrpe_pkg::PAGE_W-1:0];
                            if (r.cmd == sfrpe_pkg::OP_PROGRAM)
                            begin
                                n.st = sfrpe_pkg::SFRPE_PDATA; // [RULE10]
                            end
                            else if (r.cmd == sfrpe_pkg::OP_READ_SLOW)
                            begin
                                n.st = sfrpe_pkg::SFRPE_RDATA; // [RULE1]
                            end
                            else
                            begin
                                n.st = sfrpe_pkg::SFRPE_DUMMY; // [RULE1] [RULE6]
                            end
                        end
                    end
                    sfrpe_pkg::SFRPE_DUMMY:
                    begin
                        n.st = sfrpe_pkg::SFRPE_RDATA;
                    end
                    sfrpe_pkg::SFRPE_PDATA:
                    begin
                        // Overwriting on wrap keeps the newest page of data
                        n.pbuf[r.pg_off] = sh_next; // [RULE13]
                        n.mask[r.pg_off] = 1'h1;
                        n.pg_off         = r.pg_off + 8'h01; // [RULE12]
                        n.got_byte       = 1'h1;
                    end
                    sfrpe_pkg::SFRPE_ASI:
                    begin
                        n.asi_on = 1'h1; // [RULE20]
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
        else if (sck_fall && (r.st == sfrpe_pkg::SFRPE_RDATA || r.st == sfrpe_pkg::SFRPE_STAT))
        begin
            if (r.ocnt == 3'h0)
            begin
                if (r.st == sfrpe_pkg::SFRPE_STAT)
                begin
                    obyte = status_byte(r.busy, r.write_enable_latch, r.program_error_flag);
                end
                else
                begin
                    obyte     = ARR_RD_DATA;
                    n.rd_addr = r.rd_addr + 19'h00001; // [RULE3] [RULE4] [RULE8]
                end
            end
            n.so      = obyte[7]; // [RULE26]
            n.so_oe_n = 1'h0;
            if (dual && r.st == sfrpe_pkg::SFRPE_RDATA)
            begin
                n.bidir_second_line      = obyte[6]; // [RULE7]
                n.sio_oe_n = 1'h0; // [RULE27]
                n.osh      = {obyte[5:0], 2'h0};
                n.ocnt     = (r.ocnt == sfrpe_pkg::DUAL_LAST) ? 3'h0 : r.ocnt + 3'h1;
            end
            else
            begin
                n.osh  = {obyte[6:0], 1'h0}; // [RULE3]
                n.ocnt = r.ocnt + 3'h1;
            end
        end
        // Completion shows without any further clock from the host
        if (!r.cs_s2 && r.st == sfrpe_pkg::SFRPE_ASI && r.asi_on)
        begin
            n.so_oe_n = 1'h0;
            n.so      = r.busy; // [RULE20]
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            r          <= '0;
            r.cs_s1    <= 1'h1;
            r.cs_s2    <= 1'h1;
            r.cs_d     <= 1'h1;
            r.so_oe_n  <= 1'h1;
            r.sio_oe_n <= 1'h1;
        end
        else
        begin
            r <= n;
        end
    end

    assign SPI_SO                 = r.so;
    assign SPI_SO_OE_N            = r.so_oe_n;
    assign BIDIR_SECOND_LINE_OUT  = r.bidir_second_line;
    assign BIDIR_SECOND_LINE_OE_N = r.sio_oe_n;
    assign ARR_RD_ADDR            = r.rd_addr;
    assign ARR_WR_VALID           = fifo_out_vld;
    assign ARR_WR_ADDR            = fifo_out_data[sfrpe_pkg::WR_W-1:sfrpe_pkg::BYTE_W];
    assign ARR_WR_DATA            = fifo_out_data[sfrpe_pkg::BYTE_W-1:0];
    assign STATUS_BUSY            = r.busy;
    assign WRITE_ENABLE_LATCH     = r.write_enable_latch;
    assign PROGRAM_ERROR_FLAG     = r.program_error_flag;

    so_release_a: // [RULE5]
    assert property (@(posedge REF_CLK) disable iff (SRST) $rose(r.cs_s2) |=> SPI_SO_OE_N)
        else $error("Output still driven after deselect");
    sio_release_a: // [RULE9]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        r.cs_s2 |=> BIDIR_SECOND_LINE_OE_N [*2])
        else $error("Second line driven while deselected");
    sio_after_dummy_a: // [RULE27]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        !BIDIR_SECOND_LINE_OE_N |-> (r.st == sfrpe_pkg::SFRPE_RDATA
        && r.cmd == sfrpe_pkg::OP_READ_DUAL))
        else $error("Second line driven outside dual data phase");
    read_wrap_a: // [RULE4]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        ($past(r.st) == sfrpe_pkg::SFRPE_RDATA && $past(r.rd_addr) == sfrpe_pkg::ADDR_TOP
        && r.rd_addr != $past(r.rd_addr)) |-> r.rd_addr == '0)
        else $error("Read address did not wrap to zero");
    prog_wel_a: // [RULE11]
    assert property (@(posedge REF_CLK) disable iff (SRST) $rose(r.busy) |-> $past(r.write_enable_latch))
        else $error("Program started without write latch");
    wel_cleared_a: // [RULE21]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        $rose(STATUS_BUSY) |-> !WRITE_ENABLE_LATCH ##1 !WRITE_ENABLE_LATCH)
        else $error("Write latch still set during program");
    page_wrap_a: // [RULE12]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        ARR_WR_VALID |-> ARR_WR_ADDR[sfrpe_pkg::ADDR_W-1:sfrpe_pkg::PAGE_W] == r.pg_base)
        else $error("Program write left its page");
    abort_wel_a: // [RULE18]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        (cs_off && prog_sel && (r.bitcnt != 3'h0 || !r.got_byte))
        |=> !WRITE_ENABLE_LATCH && !r.draining)
        else $error("Aborted program left latch set");
    protect_a: // [RULE17]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        (cs_off && prog_sel && PROTECT_IN) |=> !r.draining && r.st == sfrpe_pkg::SFRPE_IDLE)
        else $error("Protected program was started");
    asi_done_a: // [RULE20]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        (!r.cs_s2 && r.st == sfrpe_pkg::SFRPE_ASI && r.asi_on && !r.busy)
        |=> !SPI_SO_OE_N && !SPI_SO)
        else $error("Completion not signalled low");
    epe_set_a: // [RULE22]
    assert property (@(posedge REF_CLK) disable iff (SRST)
        (ARR_WR_VALID && ARR_WR_READY && ARR_WR_FAIL) |=> PROGRAM_ERROR_FLAG)
        else $error("Program failure not flagged");
endmodule
`default_nettype wire

/* File: design/sfrpe_pkg.sv */
`default_nettype none
package sfrpe_pkg;
    localparam int ADDR_W     = 19;
    localparam int BYTE_W     = 8;
    localparam int PAGE_W     = 8;
    localparam int BASE_W     = ADDR_W - PAGE_W;
    localparam int WR_W       = ADDR_W + BYTE_W;
    localparam int FIFO_DEPTH = 16;

    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_DUAL = 8'h3B;
    localparam logic [7:0] OP_PROGRAM   = 8'h02;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABL = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_ACT_STAT  = 8'h25;

    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [2:0] DUAL_LAST     = 3'h3;
    localparam logic [1:0] ADDR_LAST     = 2'h2;
    localparam logic [7:0] PAGE_LAST     = 8'hFF;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 19'h7FFFF;

    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT  = 1;
    localparam int ST_EPE_BIT  = 5;

    typedef enum logic [3:0] {
        SFRPE_IDLE  = 4'h0,
        SFRPE_OPC   = 4'h1,
        SFRPE_ADDR  = 4'h3,
        SFRPE_DUMMY = 4'h2,
        SFRPE_RDATA = 4'h6,
        SFRPE_PDATA = 4'h7,
        SFRPE_STAT  = 4'h5,
        SFRPE_ASI   = 4'h4,
        SFRPE_IGN   = 4'hC
    } sfrpe_state_t;
endpackage
`default_nettype wire

/* File: tb/sfrpe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfrpe_host (
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic bidir_second_line
);
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // Seven clocks low, six high: slow enough for every read kind
    task automatic xfer(input int n, input logic [63:0] tx, input bit keep,
                        output logic [63:0] rso, output logic [63:0] rsio);
        rso = '0;
        rsio = '0;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk) si <= tx[i];
            repeat (5) @(posedge clk);
            @(posedge clk)
            begin
                rso[i] = so;
                rsio[i] = bidir_second_line;
                sck <= 1'b1;
            end
            repeat (5) @(posedge clk);
            @(posedge clk) sck <= 1'b0;
        end
        if (!keep)
            deselect();
    endtask
    // Select stays low after a kept frame until this is called
    task automatic deselect;
        repeat (3) @(posedge clk);
        @(posedge clk) cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, srst, prot, rdy, fail, hold, efail, so, so_z, s2, s2_z, vld, busy, write_enable_latch, program_error_flag;
    logic [7:0]  rdat, wd;
    logic [18:0] ra, wa;
    logic [63:0] rso, rsio;
    logic [26:0] wq [$];
    logic        pe;
    wire         cs_n, sck, si_h;
    wire         sio_w = s2_z ? si_h : s2;
    // Undriven output floats to the inverse of its last value
    wire         so_w = so_z ? !so : so;
    int          bad_count, checked, seed;
    sfrpe_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si_h), .so(so_w), .bidir_second_line(sio_w));
    sfrpe_engine u_dut (.REF_CLK(clk), .SRST(srst), .SPI_CS_N(cs_n), .SPI_SCK(sck),
        .BIDIR_SECOND_LINE_IN(sio_w), .BIDIR_SECOND_LINE_OUT(s2), .BIDIR_SECOND_LINE_OE_N(s2_z),
        .SPI_SO(so), .SPI_SO_OE_N(so_z), .PROTECT_IN(prot), .ARR_RD_ADDR(ra),
        .ARR_RD_DATA(rdat), .ARR_WR_VALID(vld), .ARR_WR_READY(rdy), .ARR_WR_FAIL(fail),
        .ARR_WR_ADDR(wa), .ARR_WR_DATA(wd), .STATUS_BUSY(busy),
        .WRITE_ENABLE_LATCH(write_enable_latch), .PROGRAM_ERROR_FLAG(program_error_flag));
    function automatic logic [7:0] arr(input logic [18:0] a);
        return a[7:0] ^ a[18:11] ^ 8'h3C;
    endfunction
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Array model: random stalls and verify failures, writes logged
    always @(posedge clk)
    begin
        rdat <= arr(ra);
        rdy <= hold ? 1'b0 : 1'($random(seed));
        fail <= 1'($random(seed));
        if (vld && rdy)
        begin
            wq.push_back({wa, wd});
            efail |= fail;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int dum, input bit dual);
        logic [19:0] d, g;
        int          k;
        k = dum + (dual ? 10 : 20);
        d = 20'({arr(a[18:0]), arr(a[18:0] + 19'h1), arr(a[18:0] + 19'h2)} >> 4);
        u_host.xfer(32 + k, 64'({op, a}) << k, 0, rso, rsio);
        g = rso[19:0];
        for (int j = 0; j < 10 && dual; j++)
            {g[19 - 2 * j], g[18 - 2 * j]} = {rso[9 - j], rsio[9 - j]};
        chk("rdata", g, d);
        chk("released", {so_z, s2_z}, 2'b11);
    endtask
    task automatic prog(input logic [23:0] a, input int nb, input logic p, input logic w);
        logic [23:0] dat;
        logic [7:0]  k;
        logic        go;
        int          q;
        dat = 24'($random(seed));
        go  = nb == 24 && !p && w;
        q   = 0;
        @(posedge clk) hold <= 1'b1;
        efail = 1'b0;
        wq.delete();
        if (w) u_host.xfer(8, 64'(sfrpe_pkg::OP_WR_ENABLE), 0, rso, rsio);
        chk("latch set", write_enable_latch, w);
        @(posedge clk) prot <= p;
        u_host.xfer(32 + nb, 64'({sfrpe_pkg::OP_PROGRAM, a, dat}) >> (24 - nb), 0, rso, rsio);
        chk("busy", busy, go);
        chk("latch", write_enable_latch, 0);
        // Array held off, so the poll and the interrupt wait see a busy device whenever the program started
        u_host.xfer(16, 64'({sfrpe_pkg::OP_RD_STATUS, 8'h00}), 0, rso, rsio);
        chk("status", rso[7:0], {2'b00, (go ? 1'b0 : pe), 4'h0, go});
        u_host.xfer(16, 64'({sfrpe_pkg::OP_ACT_STAT, 8'h00}), 1, rso, rsio);
        chk("asi busy", {so_z, so}, {1'b0, go});
        @(posedge clk) hold <= 1'b0;
        for (int i = 0; i < 300 && busy === 1'b1; i++) @(posedge clk);
        chk("busy end", busy, 0);
        repeat (2) @(posedge clk);
        chk("asi done", {so_z, so}, 2'b00);
        u_host.deselect();
        chk("count", wq.size(), go ? 3 : 0);
        // Writes leave in offset order, so bytes wrapped to the page start come first
        for (int o = 0; o < 256; o++)
        begin
            k = 8'(o - a[7:0]);
            if (k < 8'h03 && q < wq.size())
            begin
                chk("write", wq[q], {a[18:8], 8'(o), dat[23 - 8 * k -: 8]});
                q++;
            end
        end
        if (wq.size() > 0) chk("error flag", program_error_flag, efail);
        if (go) pe = efail;
        @(posedge clk) prot <= 1'b0;
    endtask
    task automatic complete_run;
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        complete_run();
    end
    initial
    begin
        {seed, srst, prot, hold, efail, pe} = {32'd53, 5'b10000};
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        rd(sfrpe_pkg::OP_READ_SLOW, 24'hFFFFFE, 0, 0);
        rd(sfrpe_pkg::OP_READ_FAST, 24'h812345, 8, 0);
        rd(sfrpe_pkg::OP_READ_DUAL, 24'h07FFFF, 8, 1);
        prog(24'hF3A2FE, 24, 1'b0, 1'b1);
        prog(24'h0102FE, 12, 1'b0, 1'b1);
        prog(24'h0102FE, 8, 1'b1, 1'b1);
        prog(24'h0102FE, 24, 1'b0, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
